/* vdip_map.vh */
// vdip_map.vh: constants for the two-wire register port of the video decoder
// assumes inclusion by bare name from the port's design files
`ifndef VDIP_MAP_VH
`define VDIP_MAP_VH
`define VDIP_CORE_CLK_HZ 50000000
`define VDIP_SCL_MAX_HZ 400000
`define VDIP_BYTE_BITS 4'h8
`define VDIP_ACK_BIT 4'h8
`define VDIP_ADDR_GND 7'h21
`define VDIP_ADDR_VDD 7'h20
`define VDIP_ADDR_SDA 7'h22
`define VDIP_STRAP_GND 2'h0
`define VDIP_STRAP_VDD 2'h1
`define VDIP_STRAP_SDA 2'h2
`define VDIP_PTR_RESET 8'h00
`define VDIP_DIR_READ 1'b1
`endif

/* vdip_regmem.v */
// vdip_regmem.v: register storage behind the serial port
// assumes one clock; read data comes out of a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module vdip_regmem #(
  parameter AW = 4,
  parameter DW = 8
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire wr_en,
  input wire [7:0] addr,
  input wire [DW-1:0] wr_data,
  output reg [DW-1:0] rd_data
);
  localparam DEPTH = 1 << AW;
  reg [DW-1:0] mem [0:DEPTH-1];
  wire [AW-1:0] idx = addr[AW-1:0];
  wire in_range = (addr >> AW) == 8'h00;

  always @(posedge clk) begin
    if (ce && wr_en && in_range) begin
      mem[idx] <= wr_data;
    end
  end

  // out-of-range pointers read as zero rather than aliasing
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= {DW{1'b0}};
    end else if (ce) begin
      rd_data <= in_range ? mem[idx] : {DW{1'b0}};
    end
  end
endmodule
`default_nettype wire

/* vdip_port.v */
// vdip_port.v: two-wire serial slave port, top of the register port
// assumes SCL and SDA arrive asynchronous; oversampled by CORE_CLK at 50 MHz
// Behaviour
// - works with master clock at any rate up to 400 kHz; master starts all.
// - each byte is eight bits plus one acknowledge clock.
// - data line only pulled low or released; clock line never driven.
// - one bit per clock; data changes only while clock low.
// - start is data falling with clock high; stop is data rising.
// - repeated start keeps transaction open and decodes fresh address byte.
// - stop recognised at any bit position; master avoids stop with start.
// - first byte is seven-bit address MSB first then direction bit.
// - address chosen by strap; grounded strap answers 0x42 and 0x43.
// - acknowledge by holding data low for whole ninth clock.
// - matching read address acknowledged before data is sent.
// - first written byte loads pointer, writes no register.
// - further written bytes stored at pointer, pointer then increments.
// - read address right after start resets pointer to zero.
// - indexed read: write address, index, repeated start, read address.
// - read bits shifted out so valid at rising clock edge.
// - pointer advances after each read byte.
// - stop after any number of read bytes releases data line.
`timescale 1ns/1ps
`default_nettype none
`include "vdip_map.vh"
module vdip_port #(
  parameter AW = 4
) (
  input wire CORE_CLK,
  input wire RESETN,
  input wire CLK_EN,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire [1:0] ADDR_STRAP,
  output reg [7:0] REG_PTR,
  output reg [7:0] WR_DATA,
  output reg WR_STROBE,
  output wire BUS_BUSY
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_PTR = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_IGNORE = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and line edges
  reg [1:0] scl_sync_reg, sda_sync_reg;
  reg scl_d_reg, sda_d_reg;
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (CLK_EN) begin
      scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end
  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  // oversampling by 125x of 400 kHz leaves ample margin for edge order
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_det = scl & scl_d_reg & sda_d_reg & ~sda;
  wire stop_det = scl & scl_d_reg & ~sda_d_reg & sda;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  reg [6:0] my_addr_reg;
  reg strap_done_reg;
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      my_addr_reg <= `VDIP_ADDR_GND;
      strap_done_reg <= 1'b0;
    end else if (CLK_EN && !strap_done_reg) begin
      strap_done_reg <= 1'b1;
      case (ADDR_STRAP)
        `VDIP_STRAP_VDD: my_addr_reg <= `VDIP_ADDR_VDD;
        `VDIP_STRAP_SDA: my_addr_reg <= `VDIP_ADDR_SDA;
        default: my_addr_reg <= `VDIP_ADDR_GND;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  wire [7:0] rd_data;
  reg mem_wr_reg;
  vdip_regmem #(.AW(AW), .DW(8)) u_mem (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .ce(CLK_EN),
    .wr_en(mem_wr_reg),
    .addr(REG_PTR),
    .wr_data(WR_DATA),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bit engine
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg sda_low_reg;
  reg ack_phase_reg;
  reg rd_ack_ok_reg;
  reg fresh_start_reg;
  wire [7:0] rx_byte = {shift_reg[6:0], sda};

  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_low_reg;
  // a foreign address leaves the port quiet, so it does not count as busy
  assign BUS_BUSY = (state_reg != ST_IDLE) && (state_reg != ST_IGNORE);

  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      sda_low_reg <= 1'b0;
      ack_phase_reg <= 1'b0;
      rd_ack_ok_reg <= 1'b0;
      fresh_start_reg <= 1'b0;
      REG_PTR <= `VDIP_PTR_RESET;
      WR_DATA <= 8'h00;
      WR_STROBE <= 1'b0;
      mem_wr_reg <= 1'b0;
    end else if (CLK_EN) begin
      WR_STROBE <= 1'b0;
      mem_wr_reg <= 1'b0;
      if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_low_reg <= 1'b0;
        ack_phase_reg <= 1'b0;
      end else if (start_det) begin
        // repeated start in an active transfer keeps the pointer; a start from idle or ignore marks reset
        fresh_start_reg <= (state_reg == ST_IDLE) || (state_reg == ST_IGNORE);
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_low_reg <= 1'b0;
        ack_phase_reg <= 1'b0;
      end else if (state_reg != ST_IDLE && state_reg != ST_IGNORE) begin
        if (scl_rise && !ack_phase_reg && state_reg != ST_RDATA) begin
          shift_reg <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (scl_rise && ack_phase_reg && state_reg == ST_RDATA) begin
          rd_ack_ok_reg <= ~sda;
        end
        if (scl_fall) begin
          if (ack_phase_reg) begin
            // ninth clock over: release, then pick next phase
            ack_phase_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
            if (state_reg == ST_RDATA) begin
              if (rd_ack_ok_reg) begin
                // pointer settled long before; an extra cycle here would miss
                // the low half of a fast clock
                shift_reg <= rd_data;
                sda_low_reg <= ~rd_data[7];
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
          end else if (state_reg == ST_RDATA) begin
            if (bit_cnt_reg == `VDIP_ACK_BIT - 4'h1) begin
              ack_phase_reg <= 1'b1;
              sda_low_reg <= 1'b0;
              REG_PTR <= REG_PTR + 8'h01;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_low_reg <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end else if (bit_cnt_reg == `VDIP_BYTE_BITS) begin
            ack_phase_reg <= 1'b1;
            case (state_reg)
              ST_ADDR: begin
                if (shift_reg[7:1] == my_addr_reg) begin
                  sda_low_reg <= 1'b1;
                  if (shift_reg[0] == `VDIP_DIR_READ) begin
                    state_reg <= ST_RDATA;
                    bit_cnt_reg <= 4'h0;
                    if (fresh_start_reg) begin
                      REG_PTR <= `VDIP_PTR_RESET;
                    end
                  end else begin
                    state_reg <= ST_PTR;
                  end
                end else begin
                  state_reg <= ST_IGNORE;
                  ack_phase_reg <= 1'b0;
                end
              end
              ST_PTR: begin
                REG_PTR <= shift_reg;
                sda_low_reg <= 1'b1;
                state_reg <= ST_WDATA;
              end
              ST_WDATA: begin
                WR_DATA <= shift_reg;
                WR_STROBE <= 1'b1;
                mem_wr_reg <= 1'b1;
                sda_low_reg <= 1'b1;
              end
              default: state_reg <= ST_IGNORE;
            endcase
          end
        end
      end
      // pointer advance after a write lands one cycle after the strobe
      if (mem_wr_reg) begin
        REG_PTR <= REG_PTR + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* vdip_port_checker.sv */
// checker: output timing of the two-wire register port
// assumes it is bound to vdip_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module vdip_port_checker #(
  parameter AW = 4
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic [1:0] ADDR_STRAP,
  input wire logic [7:0] REG_PTR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STROBE,
  input wire logic BUS_BUSY
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  AST_NO_HIGH: assert property (SDA_OUT == 1'b0) else $error("sda driven high");
  // sync delay: a change is judged against the clock two samples back
  AST_EDGE_LOW: assert property (!$stable(SDA_OE) |-> !$past(SCL_IN, 2)) else $error("oe moved");
  AST_HOLD_HIGH: assert property (SCL_IN && $past(SCL_IN, 3) |-> $stable(SDA_OE)) else $error("oe hold");
  AST_PULSE: assert property (WR_STROBE |=> !WR_STROBE) else $error("strobe width");
  AST_PTR_INC: assert property (WR_STROBE |=> REG_PTR == $past(REG_PTR) + 8'h01) else $error("ptr");
  AST_STB_BUSY: assert property (WR_STROBE |-> BUS_BUSY) else $error("stray strobe");
  AST_OE_BUSY: assert property (SDA_OE |-> BUS_BUSY) else $error("stray pull");
  AST_PTR_IDLE: assert property (!BUS_BUSY ##1 !BUS_BUSY |-> $stable(REG_PTR)) else $error("ptr idle");
  cover property (WR_STROBE);
  cover property (SDA_OE && SCL_IN);
  cover property ($fell(BUS_BUSY));
endmodule
bind vdip_port vdip_port_checker #(.AW(AW)) u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .CLK_EN(CLK_EN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .ADDR_STRAP(ADDR_STRAP), .REG_PTR(REG_PTR), .WR_DATA(WR_DATA), .WR_STROBE(WR_STROBE),
  .BUS_BUSY(BUS_BUSY));
`default_nettype wire

/* vdip_mst_model.sv */
// two-wire bus master model on the far side of the port
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module vdip_mst_model #(
  parameter int H = 80
) (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  localparam int Q = H / 2;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // entered just after a clock fall; data moves only in the low half
  task bitx(input logic b, output logic r);
    #Q sda_oe = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  // repeated start waits for the device to drop its acknowledge first
  task start;
    if (!scl) begin
      sda_oe = 1'b0;
      #(H + Q) scl = 1'b1;
    end
    #Q sda_oe = 1'b1;
    #Q scl = 1'b0;
  endtask
  task stop;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #(2 * H);
  endtask
  task byte9(input logic [8:0] o, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bitx(o[i], q[i]);
  endtask
endmodule
`default_nettype wire

/* vdip_port_tb_top.sv */
// bench: refused and aborted transfers, writes, indexed and plain reads
// assumes the master model on the link and the bound checker
`timescale 1ns/1ps
`default_nettype none
module vdip_port_tb_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, mst_oe, dut_oe, sda_o, strobe, busy;
  logic [7:0] ptr, wdat;
  logic [8:0] q;
  int fails, n_tests, n_wr, cyc, w0;
  // pull-up on the line; each side may only pull low
  wire sda = (dut_oe ? sda_o : 1'b1) && !mst_oe;
  vdip_port #(.AW(4)) dut (.CORE_CLK(core_clk), .RESETN(resetn), .CLK_EN(1'b1),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(dut_oe), .ADDR_STRAP(2'h0),
    .REG_PTR(ptr), .WR_DATA(wdat), .WR_STROBE(strobe), .BUS_BUSY(busy));
  vdip_mst_model #(.H(80)) mst (.scl(scl), .sda_oe(mst_oe), .sda(sda));
  initial forever #10 core_clk = !core_clk;
  always @(posedge core_clk) begin
    cyc++;
    n_wr += int'(strobe === 1'b1);
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] d, input logic ack);
    mst.byte9({d, 1'b1}, q);
    chk("ack", {7'h00, !q[0]}, {7'h00, ack});
  endtask
  task rd(input logic more, input logic [7:0] exp);
    mst.byte9({8'hFF, !more}, q);
    chk("rdata", q[8:1], exp);
  endtask
  task stop_test;
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task s_refuse;
    w0 = n_wr;
    mst.start();
    wr(8'h40, 1'b0);
    wr(8'h00, 1'b0);
    chk("busy", {7'h00, busy}, 8'h00);
    mst.stop();
    mst.start();
    wr(8'h42, 1'b1);
    wr(8'h02, 1'b1);
    repeat (3) mst.bitx(1'b0, q[0]);
    mst.stop();
    chk("busy", {7'h00, busy}, 8'h00);
    chk("stores", 8'(n_wr - w0), 8'h00);
  endtask
  task s_write;
    w0 = n_wr;
    mst.start();
    wr(8'h42, 1'b1);
    wr(8'h00, 1'b1);
    chk("ptr", ptr, 8'h00);
    wr(8'h5A, 1'b1);
    chk("wdata", wdat, 8'h5A);
    wr(8'hA5, 1'b1);
    wr(8'h3C, 1'b1);
    mst.stop();
    chk("ptr", ptr, 8'h03);
    chk("stores", 8'(n_wr - w0), 8'h03);
  endtask
  task s_read;
    mst.start();
    wr(8'h42, 1'b1);
    wr(8'h01, 1'b1);
    mst.start();
    wr(8'h43, 1'b1);
    rd(1'b1, 8'hA5);
    rd(1'b0, 8'h3C);
    mst.stop();
    chk("oe", {7'h00, dut_oe}, 8'h00);
    mst.start();
    wr(8'h43, 1'b1);
    rd(1'b0, 8'h5A);
    mst.stop();
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    s_refuse();
    s_write();
    s_read();
    stop_test();
  end
endmodule
`default_nettype wire
